// [core/pou_consts.vh]
// pou_consts.vh: offsets, reset values and timing counts of the
// octal serial front end. assumes a 200 MHz system clock.
`ifndef POU_CONSTS_VH
`define POU_CONSTS_VH
// ------------------------------------------------------------
// window layout
// ------------------------------------------------------------
`define POU_CH_SPAN      7'h40
`define POU_SUMMARY_OFF  7'h40
`define POU_WINDOW_SIZE  7'h41
// per-channel standard register offsets
`define POU_REG_DATA     3'h0
`define POU_REG_IER      3'h1
`define POU_REG_IIR      3'h2
`define POU_REG_LCR      3'h3
`define POU_REG_MCR      3'h4
`define POU_REG_LSR      3'h5
`define POU_REG_MSR      3'h6
`define POU_REG_SCR      3'h7
// ------------------------------------------------------------
// reset values and interrupt codes
// ------------------------------------------------------------
`define POU_DIV_RESET    16'h000C
`define POU_LCR_RESET    8'h03
`define POU_IIR_NONE     4'h1
`define POU_IIR_LINE     4'h6
`define POU_IIR_RXDATA   4'h4
`define POU_IIR_THRE     4'h2
// ------------------------------------------------------------
// timing: 1.8432 MHz reference from a 200 MHz clock, as a
// 32-bit phase step (ref * 2^32 / clk), and the same times eight
// ------------------------------------------------------------
`define POU_REF_STEP     32'h025BFAD3
`define POU_REF_STEP_X8  32'h12DFD695
`define POU_OVERSAMPLE   6'h10
`define POU_HALF_BIT     6'h08
`define POU_STOP_ONEHALF 6'h18
`define POU_STOP_TWO     6'h20
`define POU_FIFO_DEPTH   64
`define POU_FIFO_AW      6
`endif

// [core/pou_front_end.v]
// pou_front_end.v: eight serial channels and a shared interrupt
// summary in one host I/O window, plus the channel FIFO module.
// assumes io strobes are one-cycle pulses synchronous to clk and
// that window_base comes from the host's address assignment.
// Operation
// [R1] eight channels, eight byte registers each, filling the first 64 offsets
// [R2] shared interrupt summary register at window offset 0x40
// [R3] jumpers sampled at every reset set auto direction per channel
// [R4] host sees only the eight standard registers per channel
// [R5] every baud generator runs from a 1.8432 MHz reference
// [R6] normal range: divisor 1 gives 115200, 12 gives 9600, inverse scaling
// [R7] without times-eight, rates reach only 115200 baud
// [R8] times-eight: divisor 1 gives 921.6 kbps, divisor 8 gives 115200
// [R9] five to eight data bits, even/odd/no parity, 1, 1.5 or 2 stops
// [R10] window decoded at any host-placed base in 16-bit I/O space
// [R11] fixed maker and product identification codes exposed
// [R12] host reads its assigned base rather than setting it
// [R13] times-eight jumper extends range to 921600, else stops at 115200
// [R14] auto direction drives the line only while transmitting
// [R15] 64-byte transmit and receive queues, controlled by FIFO control
// [R16] summary bit n is channel n's pending interrupt
// [R17] baud equals reference over sixteen times divisor, reference x8 option
`timescale 1ns/1ps
`default_nettype none
`include "pou_consts.vh"

// ------------------------------------------------------------
// first-in first-out queue
// ------------------------------------------------------------
module pou_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             clr,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      cnt;
  wire            push = in_valid & in_ready;
  wire            pop  = out_valid & out_ready;
  assign in_ready  = (cnt != FULL);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data  = mem[rp];
  // pointers wrap naturally since depth is a power of two
  always @(posedge clk) begin
    if (rst | clr) begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  always @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule // pou_fifo

// ------------------------------------------------------------
// top: window decode, channels, summary
// ------------------------------------------------------------
module pou_front_end #(
  parameter [15:0] MAKER_ID   = 16'h1234, // arbitrary value
  parameter [15:0] PRODUCT_ID = 16'h5678  // arbitrary value
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // host I/O window
  input  wire [15:0] window_base,
  input  wire [15:0] io_addr,
  input  wire        io_rd,
  input  wire        io_wr,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  output reg         io_ack,
  output reg         irq,
  // identification
  output reg  [15:0] maker_identifier,
  output reg  [15:0] product_identifier,
  // jumpers
  input  wire [7:0]  auto_direction_jumper,
  input  wire        baud_range_times_eight,
  // serial side
  input  wire [7:0]  ser_rx,
  output reg  [7:0]  ser_tx,
  output reg  [7:0]  drv_en
);
  wire [15:0] off      = io_addr - window_base;               // [R10]
  wire        in_chans = (off[15:6] == 10'h000);              // [R1]
  wire        in_sum   = (off == {9'h000, `POU_SUMMARY_OFF}); // [R2]
  wire [2:0]  reg_sel  = off[2:0]; // only eight per channel  // [R4]
  wire [7:0]  ch_hit;
  wire [63:0] ch_rd;
  wire [7:0]  ch_pend;
  wire [7:0]  ch_tx;
  wire [7:0]  ch_busy;
  wire [7:0]  ch_rts;
  reg  [7:0]  auto_dir;
  reg  [31:0] phase;
  reg         ref_tick;
  reg  [7:0]  sel_rd;
  integer     k;

  // ------------------------------------------------------------
  // shared 1.8432 MHz reference, optionally eight times faster
  // ------------------------------------------------------------
  // phase accumulator: mean rate exact, jitter one clk (5 ns)
  always @(posedge clk) begin
    if (rst) begin
      phase    <= 32'h00000000;
      ref_tick <= 1'b0;
    end else begin
      {ref_tick, phase} <= {1'b0, phase} + {1'b0,
        (baud_range_times_eight ? `POU_REF_STEP_X8 // [R8] [R13]
                                : `POU_REF_STEP)}; // [R5] [R7]
    end
  end

  // direction jumpers read only at reset; later changes wait for next reset (the times-eight jumper acts at once)
  always @(posedge clk) begin
    if (rst) auto_dir <= auto_direction_jumper; // [R3]
  end

  // host read mux, one cycle latency, registered outputs
  always @* begin
    sel_rd = 8'h00;
    for (k = 0; k < 8; k = k + 1)
      if (ch_hit[k]) sel_rd = ch_rd[8*k +: 8];
  end
  always @(posedge clk) begin
    if (rst) begin
      io_rdata <= 8'h00;
      io_ack   <= 1'b0;
      irq      <= 1'b0;
      ser_tx   <= 8'hFF;
      drv_en   <= 8'h00;
      maker_identifier   <= 16'h0000;
      product_identifier <= 16'h0000;
    end else begin
      io_ack   <= io_rd | io_wr;
      if (io_rd) io_rdata <= in_sum ? ch_pend : sel_rd; // [R16]
      irq      <= |ch_pend;
      ser_tx   <= ch_tx;
      maker_identifier   <= MAKER_ID;   // [R11]
      product_identifier <= PRODUCT_ID; // [R11]
      // auto channels drive only while a character is queued or on the line
      drv_en   <= (auto_dir & ch_busy) | (~auto_dir & ch_rts); // [R14]
    end
  end

  // ------------------------------------------------------------
  // per-channel uart
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ch
      reg  [15:0] divisor;
      reg  [15:0] div_cnt;
      reg         tick;
      reg  [3:0]  ier;
      reg  [7:0]  lcr;
      reg  [4:0]  mcr;
      reg  [7:0]  scr;
      reg         fifo_en;
      reg  [4:1]  lsr_err;
      reg         thre_int;
      reg         tx_empty_d;
      reg         tx_on;
      reg  [10:0] tsh;
      reg  [3:0]  tbits;
      reg  [5:0]  ttk;
      reg         line;
      reg         r_on;
      reg  [3:0]  rbits;
      reg  [5:0]  rtk;
      reg  [9:0]  rsh;
      reg         rx_push;
      reg  [3:0]  iir_id;
      reg  [7:0]  rd;
      wire        sel   = in_chans & (off[5:3] == i);
      wire        dlab  = lcr[7];
      wire        wr_r  = io_wr & sel;
      wire        rd_r  = io_rd & sel;
      wire [3:0]  nbits = {2'b00, lcr[1:0]} + 4'h5;        // [R9]
      wire [7:0]  dmask = 8'hFF >> (4'h8 - nbits);
      wire        tx_v, rx_v, rx_rdy, clr_rx, clr_tx;
      wire [7:0]  tx_d, rx_d;
      wire        tx_pop  = tx_v & ~tx_on & tick;
      wire        rbr_rd  = rd_r & (reg_sel == `POU_REG_DATA) & ~dlab;
      wire        lsr_rd  = rd_r & (reg_sel == `POU_REG_LSR);
      wire        iir_rd  = rd_r & (reg_sel == `POU_REG_IIR);
      wire [5:0]  stop_tk = ~lcr[2] ? `POU_OVERSAMPLE :
                            (lcr[1:0] == 2'b00) ? `POU_STOP_ONEHALF
                                                : `POU_STOP_TWO; // [R9]
      wire [7:0]  td    = tx_d & dmask;
      wire        tpar  = lcr[5] ? ~lcr[4] : (^td ^ ~lcr[4]);
      wire [3:0]  rtot  = nbits + {3'b000, lcr[3]};
      wire [7:0]  rdat  = rsh[7:0] & dmask;
      wire        rpar  = rsh[nbits];
      // even parity when lcr[4] is set, stick parity when lcr[5] is set
      wire        pbad  = lcr[3] & (lcr[5] ? (rpar != ~lcr[4])
                                           : (^{rdat, rpar} ^ ~lcr[4]));
      assign clr_rx = wr_r & (reg_sel == `POU_REG_IIR) & io_wdata[1];
      assign clr_tx = wr_r & (reg_sel == `POU_REG_IIR) & io_wdata[2];

      // 64-byte queues each way                             [R15]
      pou_fifo #(.WIDTH(8), .DEPTH(`POU_FIFO_DEPTH), .AW(`POU_FIFO_AW))
        u_txq (.clk(clk), .rst(rst), .clr(clr_tx),
               .in_valid(wr_r & (reg_sel == `POU_REG_DATA) & ~dlab),
               .in_ready(), .in_data(io_wdata),
               .out_valid(tx_v), .out_ready(tx_pop), .out_data(tx_d));
      pou_fifo #(.WIDTH(8), .DEPTH(`POU_FIFO_DEPTH), .AW(`POU_FIFO_AW))
        u_rxq (.clk(clk), .rst(rst), .clr(clr_rx),
               .in_valid(rx_push), .in_ready(rx_rdy), .in_data(rdat),
               .out_valid(rx_v), .out_ready(rbr_rd), .out_data(rx_d));

      // sixteen-times tick: reference over divisor      [R6] [R17]
      always @(posedge clk) begin
        if (rst) begin
          div_cnt <= 16'h0000;
          tick    <= 1'b0;
        end else begin
          tick <= 1'b0;
          if (ref_tick) begin
            if (div_cnt + 16'h0001 >= divisor) begin
              div_cnt <= 16'h0000;
              tick    <= 1'b1;
            end else div_cnt <= div_cnt + 16'h0001;
          end
        end
      end

      // host-visible registers; fifo control commands act at once
      always @(posedge clk) begin
        if (rst) begin
          divisor <= `POU_DIV_RESET;
          ier     <= 4'h0;
          lcr     <= `POU_LCR_RESET;
          mcr     <= 5'h00;
          scr     <= 8'h00;
          fifo_en <= 1'b0;
        end else if (wr_r) begin
          case (reg_sel)
            `POU_REG_DATA: if (dlab) divisor[7:0] <= io_wdata;
            `POU_REG_IER: begin
              if (dlab) divisor[15:8] <= io_wdata;
              else ier <= io_wdata[3:0];
            end
            `POU_REG_IIR: fifo_en <= io_wdata[0]; // [R15]
            `POU_REG_LCR: lcr <= io_wdata;
            `POU_REG_MCR: mcr <= io_wdata[4:0];
            `POU_REG_SCR: scr <= io_wdata;
            default: ;
          endcase
        end
      end

      // sticky flags: a new event wins over a clearing read
      always @(posedge clk) begin
        if (rst) begin
          lsr_err    <= 4'h0;
          thre_int   <= 1'b0;
          tx_empty_d <= 1'b1;
        end else begin
          tx_empty_d <= ~tx_v;
          lsr_err <= (lsr_rd ? 4'h0 : lsr_err) |
            (rx_push ? {~rsh[rtot] & (rsh == 10'h000), ~rsh[rtot],
                        pbad, ~rx_rdy} : 4'h0);
          thre_int <= (~tx_v & ~tx_empty_d) |
            (thre_int & ~(iir_rd & (iir_id == `POU_IIR_THRE)) &
             ~(wr_r & (reg_sel == `POU_REG_DATA) & ~dlab));
        end
      end

      // transmitter: start, data, optional parity, stop time
      always @(posedge clk) begin
        if (rst) begin
          tx_on <= 1'b0;
          tsh   <= 11'h7FF;
          tbits <= 4'h0;
          ttk   <= 6'h00;
          line  <= 1'b1;
        end else if (tick) begin
          if (tx_pop) begin
            tx_on <= 1'b1;
            line  <= 1'b0;
            // the stop bit rides in tsh just above data and parity
            tsh   <= ({3'b000, td} | (11'h7FF << rtot)) |
                     ({10'h000, lcr[3] & tpar} << nbits);
            tbits <= rtot + 4'h1;
            ttk   <= `POU_OVERSAMPLE - 6'h01;
          end else if (tx_on) begin
            if (ttk != 6'h00) ttk <= ttk - 6'h01;
            else if (tbits != 4'h0) begin
              line  <= tsh[0];
              tsh   <= {1'b1, tsh[10:1]};
              tbits <= tbits - 4'h1;
              // last shift puts the stop bit out for the stop time
              ttk   <= (tbits == 4'h1) ? stop_tk - 6'h01
                                       : `POU_OVERSAMPLE - 6'h01; // [R9]
            end else begin
              line  <= 1'b1;
              tx_on <= 1'b0;
            end
          end
        end
      end

      // receiver: mid-bit sampling, framing and parity checks
      always @(posedge clk) begin
        if (rst) begin
          r_on    <= 1'b0;
          rbits   <= 4'h0;
          rtk     <= 6'h00;
          rsh     <= 10'h000;
          rx_push <= 1'b0;
        end else begin
          rx_push <= 1'b0;
          if (tick) begin
            if (~r_on) begin
              if (~ser_rx[i]) begin
                r_on  <= 1'b1;
                rbits <= rtot + 4'h1;
                rtk   <= `POU_HALF_BIT + `POU_OVERSAMPLE - 6'h01;
              end
            end else if (rtk != 6'h00) rtk <= rtk - 6'h01;
            else begin
              rsh[rtot - rbits + 4'h1] <= ser_rx[i];
              rtk   <= `POU_OVERSAMPLE - 6'h01;
              rbits <= rbits - 4'h1;
              if (rbits == 4'h1) begin
                r_on    <= 1'b0;
                rx_push <= 1'b1; // stop sampled, queue the character
              end
            end
          end
        end
      end

      // interrupt source by priority, and the read view
      always @* begin
        if (ier[2] & (|lsr_err)) iir_id = `POU_IIR_LINE;
        else if (ier[0] & rx_v) iir_id = `POU_IIR_RXDATA;
        else if (ier[1] & thre_int) iir_id = `POU_IIR_THRE;
        else iir_id = `POU_IIR_NONE;
        case (reg_sel)
          `POU_REG_DATA: rd = dlab ? divisor[7:0] : rx_d;
          `POU_REG_IER:  rd = dlab ? divisor[15:8] : {4'h0, ier};
          `POU_REG_IIR:  rd = {{2{fifo_en}}, 2'b00, iir_id};
          `POU_REG_LCR:  rd = lcr;
          `POU_REG_MCR:  rd = {3'b000, mcr};
          `POU_REG_LSR:  rd = {|lsr_err, ~tx_v & ~tx_on, ~tx_v,
                               lsr_err, rx_v};
          `POU_REG_SCR:  rd = scr;
          default:       rd = 8'h00;
        endcase
      end

      assign ch_hit[i]        = sel;                         // [R1]
      assign ch_rd[8*i +: 8]  = rd;
      assign ch_pend[i]       = (iir_id != `POU_IIR_NONE);   // [R16]
      assign ch_tx[i]         = line;
      assign ch_busy[i]       = tx_on | tx_v;
      assign ch_rts[i]        = mcr[1];
    end
  endgenerate
endmodule // pou_front_end
`default_nettype wire

// [verif/pou_front_end_asserts.sv]
// pou_front_end_asserts.sv: port-level checks of the octal front end.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pou_front_end_asserts #(
  parameter [15:0] MAKER_ID   = 16'h1234,
  parameter [15:0] PRODUCT_ID = 16'h5678
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // host window
  input wire logic [15:0] window_base,
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_ack,
  input wire logic        irq,
  // identification
  input wire logic [15:0] maker_identifier,
  input wire logic [15:0] product_identifier,
  // jumpers and line
  input wire logic [7:0]  auto_direction_jumper,
  input wire logic [7:0]  ser_tx,
  input wire logic [7:0]  drv_en
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  wire  [15:0] off;
  logic [7:0]  auto_q;
  assign off = io_addr - window_base;
  // direction jumpers are only meaningful as captured while reset is held
  always @(posedge clk) begin
    if (rst) begin
      auto_q <= auto_direction_jumper;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ack_follows_req: assert property ((io_rd || io_wr) |=> io_ack)
    else $error("request without acknowledge");
  a_ack_has_cause: assert property (io_ack |-> $past(io_rd || io_wr))
    else $error("acknowledge without request");
  a_unmapped_reads_zero: assert property (
    (io_rd && off > 16'h0040) |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!$past(io_rd) |-> $stable(io_rdata))
    else $error("read data moved without read");
  a_reset_idle: assert property (
    $fell(rst) |-> (ser_tx == 8'hFF && drv_en == 8'h00 && !irq))
    else $error("line not idle after reset");
  a_ids_fixed: assert property (!$fell(rst) |->
    (maker_identifier == MAKER_ID && product_identifier == PRODUCT_ID))
    else $error("identification wrong");
  a_auto_drives_line: assert property (
    (auto_q & ~ser_tx & ~drv_en) == 8'h00)
    else $error("auto channel sends with driver off");
  a_auto_release_idle: assert property (
    (auto_q & $past(drv_en) & ~drv_en & ~ser_tx) == 8'h00)
    else $error("auto driver dropped mid character");
endmodule // pou_front_end_asserts
bind pou_front_end pou_front_end_asserts #(
  .MAKER_ID(MAKER_ID), .PRODUCT_ID(PRODUCT_ID)) u_chk (
  .clk(clk), .rst(rst), .window_base(window_base), .io_addr(io_addr),
  .io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata), .io_ack(io_ack),
  .irq(irq), .maker_identifier(maker_identifier),
  .product_identifier(product_identifier),
  .auto_direction_jumper(auto_direction_jumper), .ser_tx(ser_tx),
  .drv_en(drv_en));
`default_nettype wire

// [verif/pou_line_peer.sv]
// pou_line_peer.sv: far-end serial peer, sends 8N1, receives data plus optional parity, for all eight lines.
// assumes bit times given in clk cycles; lines idle high.
`timescale 1ns/1ps
`default_nettype none
module pou_line_peer (
  // clock
  input wire logic       clk,
  // serial lines
  input wire logic [7:0] ser_tx,
  output var logic [7:0] ser_rx
);
  initial ser_rx = 8'hFF;
  // send one character, lsb first, one stop bit
  task automatic send(input int ch, input logic [7:0] d, input int bc);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      ser_rx[ch] <= f[i];
      repeat (bc - 1) @(posedge clk);
    end
  endtask
  // receive nb bits (data, then parity) mid bit; ok means stop seen
  task automatic recv(input int ch, input int bc, input int nb,
                      output logic [9:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 10'h000;
    for (n = 0; n < 40 * bc && ser_tx[ch] !== 1'b0; n++) @(negedge clk);
    if (ser_tx[ch] === 1'b0) begin
      repeat (bc / 2) @(negedge clk);
      for (int i = 0; i < nb; i++) begin
        repeat (bc) @(negedge clk);
        d[i] = ser_tx[ch];
      end
      repeat (bc) @(negedge clk);
      ok = (ser_tx[ch] === 1'b1);
    end
  endtask
endmodule // pou_line_peer
`default_nettype wire

// [verif/pci_octal_uart_front_end_bench.sv]
// pci_octal_uart_front_end_bench.sv: self-checking bench of the front end.
// assumes 200 MHz clk and the line peer on the serial side.
`timescale 1ns/1ps
`default_nettype none
module pci_octal_uart_front_end_bench;
  localparam [15:0] MID = 16'h2C4B; // arbitrary value
  localparam [15:0] PID = 16'h7E19; // arbitrary value
  logic        clk, rst, io_rd, io_wr, io_ack, irq, baud_range_times_eight;
  logic [15:0] window_base, io_addr, maker_identifier, product_identifier;
  logic [7:0]  io_wdata, io_rdata, auto_direction_jumper;
  logic [7:0]  ser_rx, ser_tx, drv_en, d, jmp;
  int          fails, n_checks, n;
  int          scr_model [8];
  int          rx_q [$];
  pou_front_end #(.MAKER_ID(MID), .PRODUCT_ID(PID)) i_dut (
    .clk(clk), .rst(rst), .window_base(window_base), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_ack(io_ack), .irq(irq),
    .maker_identifier(maker_identifier),
    .product_identifier(product_identifier),
    .auto_direction_jumper(auto_direction_jumper),
    .baud_range_times_eight(baud_range_times_eight),
    .ser_rx(ser_rx), .ser_tx(ser_tx), .drv_en(drv_en));
  pou_line_peer i_peer (.clk(clk), .ser_tx(ser_tx), .ser_rx(ser_rx));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one strobe cycle; the answer is fixed one cycle after it
  task automatic io(input bit rd, input logic [6:0] off,
                    input logic [7:0] wd, output logic [7:0] rv);
    @(posedge clk);
    io_rd <= rd;
    io_wr <= !rd;
    io_addr <= window_base + {9'h000, off};
    io_wdata <= wd;
    @(posedge clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    @(negedge clk);
    cmp("io_ack", 1, io_ack);
    rv = io_rdata;
  endtask
  task automatic wr(input logic [6:0] off, input logic [7:0] wd);
    logic [7:0] rv;
    io(1'b0, off, wd, rv);
  endtask
  task automatic rd_cmp(input string what, input logic [6:0] off,
                        input logic [7:0] exp);
    logic [7:0] rv;
    io(1'b1, off, 8'h00, rv);
    cmp(what, exp, rv);
  endtask
  task automatic do_reset(input logic [7:0] jmp);
    @(posedge clk);
    rst <= 1'b1;
    auto_direction_jumper <= jmp;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // program a channel, send one byte, let the peer decode it
  task automatic tx_check(input int ch, input int div, input logic x8,
                          input logic exp_drv, input logic [7:0] lcr);
    logic [9:0] got, want;
    logic [7:0] dv;
    logic       ok;
    logic [6:0] b;
    int         bc, nd;
    b = 7'(ch) << 3;
    dv = 8'($urandom);
    bc = (x8 ? 217014 : 1736111) * div / 1000;
    // model frame: nd data bits, then the parity bit if enabled
    nd = 5 + int'(lcr[1:0]);
    want = 10'(dv) & ((10'h001 << nd) - 10'h001);
    if (lcr[3]) want[nd] = lcr[4] ? ^want : ~^want;
    @(posedge clk);
    baud_range_times_eight <= x8;
    wr(b + 7'h03, 8'h83);
    wr(b, 8'(div));
    wr(b + 7'h01, 8'h00);
    wr(b + 7'h03, lcr);
    wr(b, dv);
    fork
      i_peer.recv(ch, bc, nd + int'(lcr[3]), got, ok);
      begin
        repeat (bc * 5) @(negedge clk);
        cmp("drv_busy", exp_drv, drv_en[ch]);
      end
    join
    cmp("tx_frame", {1'b1, want}, {ok, got});
    // two bit times also cover a second stop bit
    repeat (bc * 2) @(negedge clk);
    cmp("drv_idle", 0, drv_en[ch]);
  endtask
  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    $display("[ERR] run expected done seen hang");
    finish_test;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    baud_range_times_eight = 1'b0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'h5d5ada92));
    // any base that leaves room for the whole window, as the host assigns
    window_base = 16'($urandom_range(16'hFFB0, 0));
    // channel 0 auto, channel 1 manual, the rest random
    jmp = {6'($urandom), 2'b01};
    auto_direction_jumper = jmp;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    cmp("ser_tx", 8'hFF, ser_tx);
    cmp("maker", MID, maker_identifier);
    cmp("product", PID, product_identifier);
    for (int c = 0; c < 8; c++) begin
      rd_cmp("lcr", 7'(c * 8 + 3), 8'h03);
    end
    rd_cmp("summary", 7'h40, 8'h00);
    rd_cmp("gap", 7'h41, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      scr_model[c] = $urandom_range(255, 0);
      wr(7'(c * 8 + 7), 8'(scr_model[c]));
    end
    wr(7'h40, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      rd_cmp("scratch", 7'(c * 8 + 7), 8'(scr_model[c]));
    end
    rd_cmp("summary_ro", 7'h40, 8'h00);
    $display("test window done");
    tx_check(0, 1, 1'b1, 1'b1, 8'h03);
    tx_check(1, 8, 1'b1, 1'b0, 8'h1A);
    tx_check(2, 1, 1'b0, jmp[2], 8'h0F);
    $display("test transmit done");
    // receive on channel 3 at the top rate, data interrupt enabled
    @(posedge clk);
    baud_range_times_eight <= 1'b1;
    wr(7'h1B, 8'h83);
    wr(7'h18, 8'h01);
    wr(7'h19, 8'h00);
    wr(7'h1B, 8'h03);
    wr(7'h19, 8'h01);
    d = 8'($urandom);
    rx_q.push_back(d);
    i_peer.send(3, d, 217);
    for (n = 0; n < 600 && irq !== 1'b1; n++) @(negedge clk);
    cmp("irq", 1, irq);
    rd_cmp("summary_rx", 7'h40, 8'h08);
    rd_cmp("rbr", 7'h18, 8'(rx_q.pop_front()));
    rd_cmp("lsr_clean", 7'h1D, 8'h60);
    rd_cmp("summary_clr", 7'h40, 8'h00);
    $display("test receive done");
    // a moved direction jumper must wait for the next reset
    @(posedge clk);
    auto_direction_jumper <= 8'h00;
    tx_check(0, 1, 1'b1, 1'b1, 8'h03);
    do_reset(8'h00);
    tx_check(0, 1, 1'b1, 1'b0, 8'h03);
    $display("test jumper done");
    finish_test;
  end
endmodule // pci_octal_uart_front_end_bench
`default_nettype wire
